// file: core/cbr_pkg.sv
// shared constants and carrier types for the conversion buffer and ready logic
package cbr_pkg;
    localparam int unsigned CBR_WORD_W    = 24;   // conversion word width
    localparam int unsigned CBR_CH_W      = 2;    // channel tag width
    localparam int unsigned CBR_CLK_MHZ   = 25;   // system clock rate
    localparam int unsigned CBR_PULSE_NS  = 80;   // ready pulse width in pulse format
    // least time, rounded up to whole cycles, at least one
    localparam int unsigned CBR_PULSE_CYC =
        ((CBR_PULSE_NS * CBR_CLK_MHZ + 999) / 1000) < 1 ? 1 :
        ((CBR_PULSE_NS * CBR_CLK_MHZ + 999) / 1000);
    localparam int unsigned CBR_CNT_W     = 4;    // pulse counter width

    localparam logic        CBR_FMT_LEVEL = 1'b0; // ready as a level
    localparam logic        CBR_FMT_PULSE = 1'b1; // ready as a short pulse

    // one word on its way to the serial shifter
    typedef struct packed {
        logic [CBR_CH_W-1:0]   chan;  // channel the word belongs to
        logic                  last;  // last channel of the frame
        logic [CBR_WORD_W-1:0] data;  // conversion result
    } cbr_word_t;

    localparam int unsigned CBR_ITEM_W = $bits(cbr_word_t);

    // shifter sequencer states, gray along the path
    typedef enum logic [1:0] {
        CBR_IDLE  = 2'b00,
        CBR_SHIFT = 2'b01
    } cbr_seq_t;
endpackage

// file: core/cbr_pair_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module cbr_pair_buf #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clr,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];   // storage entries
    logic [PW-1:0]    wr_r;            // write pointer
    logic [PW-1:0]    rd_r;            // read pointer
    logic [PW:0]      cnt_r;           // entries held
    logic             push;            // accepted write
    logic             pop;             // accepted read

    assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_r[rd_r];

    // pointer wrap helper
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH-1)) ? '0 : PW'(p + 1'b1);
    endfunction

    // entry storage
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk) begin
        if (rst || clr) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= bump(wr_r);
            end
            if (pop) begin
                rd_r <= bump(rd_r);
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// file: core/cbr_top.sv
// per-channel output buffer, fifo stage, word shifter feed and ready pin
`timescale 1ns/1ps
// Notes on behaviour
// - read stage: new result loads both stages
// - repeated reads keep contents until next conversion
// - unread stage: only output buffer updates
// - reading stale result copies newer one in
// - next read shifts out the newer result
// - second unread conversion overwrites both stages
// - serial words always come from fifo stage
// - one buffer pair per channel, one word
// - level format: low until data shifted out
// - pulse format: short low pulse per result
// - level: unread at conversion gives brief high
// - pulse: unread conversion skips one pulse
// - ready flag clears with each read of a current result
// - clear strobe empties stages, restarts conversions
// - level: narrow blip after first stale read
module cbr_top
    import cbr_pkg::*;
#(
    parameter int unsigned NCH       = 3,            // channel count
    parameter int unsigned PULSE_CYC = CBR_PULSE_CYC // ready pulse cycles
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  conv_done,
    input  wire logic [CBR_WORD_W-1:0] conv_data [NCH],
    input  wire logic                  ready_signal_format,
    input  wire logic                  frame_rd,
    output cbr_word_t                  word_data,
    output logic                       word_valid,
    input  wire logic                  word_ready,
    input  wire logic                  sync_clear_pin_n,
    output logic                       restart_conv,
    output logic                       result_ready_pin_n,
    output logic [NCH-1:0]             data_ready_flag,
    output logic                       frame_busy
);
    logic [CBR_WORD_W-1:0] outbuf_r [NCH];   // output buffer per channel
    logic [CBR_WORD_W-1:0] fifo_r   [NCH];   // fifo stage per channel
    logic [NCH-1:0]        unread_r;         // fifo stage not yet read
    logic [NCH-1:0]        pending_r;        // output buffer newer than fifo
    logic [NCH-1:0]        rd_done;          // word of channel fully shifted
    logic [NCH-1:0]        reload;           // stale word read, newer copied
    logic [NCH-1:0]        skip;             // conversion lands on unread word
    logic                  word_fire;        // shifter took a word
    logic                  frame_end;        // last word of frame taken
    logic                  sync_s1_r;        // pin synchroniser, first stage
    logic                  sync_s2_r;        // pin synchroniser, second stage
    logic                  sync_s3_r;        // delayed copy for edge detect
    logic                  clear;            // clear strobe seen
    logic                  restart_r;        // restart pulse register
    cbr_seq_t              seq_r;            // sequencer state
    logic [CBR_CH_W-1:0]   idx_r;            // channel being queued
    cbr_word_t             push_item;        // word offered to buffer
    logic                  push_valid;       // word offered
    logic                  push_ready;       // buffer can take word
    logic                  lvl_low_r;        // level format holds pin low
    logic                  blip_r;           // one-cycle high blip
    logic [CBR_CNT_W-1:0]  pulse_cnt_r;      // pulse format low counter
    logic                  pin_r;            // registered pin level
    logic                  new_evt;          // conversion or reload event
    logic                  pulse_evt;        // pulse format ready event

    // pin synchroniser, the second stage and its delayed copy feed logic
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_s1_r <= 1'b1;
            sync_s2_r <= 1'b1;
            sync_s3_r <= 1'b1;
        end else begin
            sync_s1_r <= sync_clear_pin_n;
            sync_s2_r <= sync_s1_r;
            sync_s3_r <= sync_s2_r;
        end
    end

    // falling edge of the clear pin is the strobe
    assign clear = sync_s3_r & ~sync_s2_r;

    // conversion restart pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            restart_r <= 1'b0;
        end else begin
            restart_r <= clear;
        end
    end
    assign restart_conv = restart_r;

    // completed words identified by channel tag
    assign word_fire = word_valid & word_ready;
    assign frame_end = word_fire & word_data.last;

    // per-channel buffer pair
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic                  u_mid;   // unread after the read
        logic                  p_mid;   // pending after the read
        logic [CBR_WORD_W-1:0] f_mid;   // fifo after the read

        assign rd_done[c] = word_fire && (word_data.chan == CBR_CH_W'(c));
        assign reload[c]  = rd_done[c] & pending_r[c];
        // a read of a current word clears its unread state
        assign u_mid = rd_done[c] ? pending_r[c] : unread_r[c];
        assign p_mid = rd_done[c] ? 1'b0 : pending_r[c];
        assign f_mid = reload[c] ? outbuf_r[c] : fifo_r[c];
        assign skip[c] = u_mid & ~p_mid;

        // output buffer follows every conversion
        always_ff @(posedge clk) begin
            if (rst || clear) begin
                outbuf_r[c] <= '0;
            end else if (conv_done) begin
                outbuf_r[c] <= conv_data[c];
            end
        end

        // fifo stage and its read state
        always_ff @(posedge clk) begin
            if (rst || clear) begin
                fifo_r[c]    <= '0;
                unread_r[c]  <= 1'b0;
                pending_r[c] <= 1'b0;
            end else if (conv_done) begin
                if (!u_mid) begin
                    fifo_r[c]    <= conv_data[c];
                    unread_r[c]  <= 1'b1;
                    pending_r[c] <= 1'b0;
                end else if (!p_mid) begin
                    fifo_r[c]    <= f_mid;
                    unread_r[c]  <= 1'b1;
                    pending_r[c] <= 1'b1;
                end else begin
                    fifo_r[c]    <= conv_data[c];
                    unread_r[c]  <= 1'b1;
                    pending_r[c] <= 1'b0;
                end
            end else begin
                fifo_r[c]    <= f_mid;
                unread_r[c]  <= u_mid;
                pending_r[c] <= p_mid;
            end
        end
    end

    // status flags show unread words, cleared by reads
    assign data_ready_flag = unread_r;

    // shifter sequencer: queues each channel's fifo word
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            seq_r <= CBR_IDLE;
            idx_r <= '0;
        end else begin
            unique case (seq_r)
                CBR_IDLE: begin
                    if (frame_rd) begin
                        seq_r <= CBR_SHIFT;
                        idx_r <= '0;
                    end
                end
                CBR_SHIFT: begin
                    if (push_ready) begin
                        if (idx_r == CBR_CH_W'(NCH-1)) begin
                            seq_r <= CBR_IDLE;
                        end else begin
                            idx_r <= idx_r + 1'b1;
                        end
                    end
                end
                default: begin
                    seq_r <= CBR_IDLE;
                end
            endcase
        end
    end

    // words offered to the buffer come from the fifo stage only
    assign push_valid     = (seq_r == CBR_SHIFT);
    assign push_item.chan = idx_r;
    assign push_item.last = (idx_r == CBR_CH_W'(NCH-1));
    assign push_item.data = fifo_r[idx_r];
    assign frame_busy     = (seq_r == CBR_SHIFT) | word_valid;

    // two-entry buffer so a stalled shifter loses no word
    cbr_pair_buf #(
        .WIDTH (CBR_ITEM_W),
        .DEPTH (2)
    ) u_buf (
        .clk       (clk),
        .rst       (rst),
        .clr       (clear),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_item),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  (word_data)
    );

    // ready events; a conversion onto an unread channel 0 word with no newer result pending skips a pulse
    assign new_evt   = conv_done | (|reload);
    assign pulse_evt = conv_done & ~skip[0];

    // level format: low until shifted out, blip high on repeat events
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            lvl_low_r <= 1'b0;
            blip_r    <= 1'b0;
        end else if (new_evt) begin
            lvl_low_r <= 1'b1;
            blip_r    <= lvl_low_r & ~frame_end;
            if (frame_end) begin
                blip_r <= 1'b1;
            end
        end else begin
            blip_r <= 1'b0;
            if (frame_end) begin
                lvl_low_r <= 1'b0;
            end
        end
    end

    // pulse format low-time counter
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            pulse_cnt_r <= '0;
        end else if (pulse_evt) begin
            pulse_cnt_r <= CBR_CNT_W'(PULSE_CYC);
        end else if (pulse_cnt_r != '0) begin
            pulse_cnt_r <= pulse_cnt_r - 1'b1;
        end
    end

    // registered pin, high when idle
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_r <= 1'b1;
        end else if (ready_signal_format == CBR_FMT_PULSE) begin
            pin_r <= (pulse_cnt_r == '0);
        end else begin
            pin_r <= ~lvl_low_r | blip_r;
        end
    end
    assign result_ready_pin_n = pin_r;
endmodule

// file: dv/cbr_host_shifter.sv
// far-side word shifter model, prompt or stalling
`timescale 1ns/1ps
module cbr_host_shifter (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic slow,
    output logic      word_ready
);
    logic [3:0] lfsr_r; // stall pattern source
    // accepts every cycle, or stalls on a pseudo-random pattern when slow
    always_ff @(posedge clk) begin
        if (rst) begin
            lfsr_r     <= 4'h9;
            word_ready <= 1'b0;
        end else begin
            lfsr_r     <= {lfsr_r[2:0], lfsr_r[3] ^ lfsr_r[2]};
            word_ready <= !slow || lfsr_r[0];
        end
    end
endmodule

// file: dv/cbr_checker.sv
// port assertions for the conversion buffer and ready pin
`timescale 1ns/1ps
module cbr_checker
    import cbr_pkg::*;
#(
    parameter int unsigned NCH = 3
) (
    input wire logic           clk,
    input wire logic           rst,
    input wire logic           conv_done,
    input wire logic           ready_signal_format,
    input wire logic           frame_rd,
    input wire cbr_word_t      word_data,
    input wire logic           word_valid,
    input wire logic           word_ready,
    input wire logic           sync_clear_pin_n,
    input wire logic           restart_conv,
    input wire logic           result_ready_pin_n,
    input wire logic [NCH-1:0] data_ready_flag,
    input wire logic           frame_busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    flag_set_a: assert property (conv_done |=> &data_ready_flag)
        else $error("flags not set after conversion");
    flag_rise_a: assert property ($rose(data_ready_flag[0]) |-> $past(conv_done))
        else $error("flag rose without conversion");
    level_low_a: assert property (conv_done && !ready_signal_format |-> ##[2:3] !result_ready_pin_n)
        else $error("ready pin not low after conversion");
    level_idle_a: assert property ((!ready_signal_format && data_ready_flag == '0 && !frame_busy
        && !conv_done) [*3] |-> result_ready_pin_n)
        else $error("ready pin low with nothing unread");
    pulse_width_a: assert property ($fell(result_ready_pin_n) && ready_signal_format
        |=> !result_ready_pin_n ##1 result_ready_pin_n)
        else $error("ready pulse width wrong");
    restart_one_a: assert property (restart_conv |=> !restart_conv)
        else $error("restart longer than one cycle");
    clear_restart_a: assert property ($fell(sync_clear_pin_n) |-> ##[2:4] restart_conv)
        else $error("clear strobe gave no restart");
    restart_flush_a: assert property (restart_conv |-> data_ready_flag == '0 && !word_valid)
        else $error("buffers not emptied by clear");
    word_hold_a: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
        else $error("word changed while stalled");
    frame_start_a: assert property (frame_rd && !frame_busy |-> ##2 word_valid && word_data.chan == '0)
        else $error("frame did not start with channel zero");
    last_chan_a: assert property (word_valid && word_data.last |-> word_data.chan == CBR_CH_W'(NCH - 1))
        else $error("last flag on wrong channel");
    // a stale frame leaves the last flag set; the pin then blips high for one cycle
    stale_blip_a: assert property (!ready_signal_format && word_valid && word_ready && word_data.last
        |=> (data_ready_flag[NCH-1] |=> (result_ready_pin_n ##1 !result_ready_pin_n)))
        else $error("no narrow blip after stale frame");
    cover property (conv_done && data_ready_flag[0]);
    cover property (restart_conv);
    cover property ($fell(result_ready_pin_n) && ready_signal_format);
endmodule
bind cbr_top cbr_checker #(.NCH(NCH)) u_chk (.clk(clk), .rst(rst), .conv_done(conv_done),
    .ready_signal_format(ready_signal_format), .frame_rd(frame_rd), .word_data(word_data),
    .word_valid(word_valid), .word_ready(word_ready), .sync_clear_pin_n(sync_clear_pin_n),
    .restart_conv(restart_conv), .result_ready_pin_n(result_ready_pin_n),
    .data_ready_flag(data_ready_flag), .frame_busy(frame_busy));

// file: dv/tb.sv
// self-checking bench for the conversion buffer and ready logic
`timescale 1ns/1ps
module tb;
    import cbr_pkg::*;
    localparam int NCH = 3;
    logic                  clk, rst, conv_done, fmt, frame_rd, sync_n, slow, pin_q;
    logic [CBR_WORD_W-1:0] conv_data [NCH];
    logic [CBR_WORD_W-1:0] obuf [NCH];  // model output buffers
    logic [CBR_WORD_W-1:0] fifo [NCH];  // model fifo stages
    logic [NCH-1:0]        unread, pend, flags;
    logic                  word_valid, word_ready, restart_conv, pin_n, busy;
    cbr_word_t             word_data, e;
    cbr_word_t             exq [$];     // words expected on the stream
    int                    failures, num_checks, cyc, falls, restarts, seed;

    cbr_top #(.NCH(NCH), .PULSE_CYC(2)) dut (.clk(clk), .rst(rst), .conv_done(conv_done),
        .conv_data(conv_data), .ready_signal_format(fmt), .frame_rd(frame_rd),
        .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready),
        .sync_clear_pin_n(sync_n), .restart_conv(restart_conv), .result_ready_pin_n(pin_n),
        .data_ready_flag(flags), .frame_busy(busy));
    cbr_host_shifter u_host (.clk(clk), .rst(rst), .slow(slow), .word_ready(word_ready));

    // compare a stream word
    task automatic chk_word(input cbr_word_t got, input cbr_word_t exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t word got %h exp %h", $time, got, exp);
        end
    endtask
    // compare a flag, pin or count
    task automatic chk_sig(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t value got %h exp %h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one conversion on all channels, model updated alongside
    task automatic conv();
        logic [CBR_WORD_W-1:0] v;
        @(posedge clk);
        conv_done <= 1'b1;
        for (int i = 0; i < NCH; i++) begin
            v = CBR_WORD_W'($random(seed));
            conv_data[i] <= v;
            fifo[i] = (unread[i] && !pend[i]) ? fifo[i] : v;
            pend[i] = unread[i] && !pend[i];
            unread[i] = 1'b1;
            obuf[i] = v;
        end
        @(posedge clk);
        conv_done <= 1'b0;
        repeat (10) @(posedge clk);
    endtask
    // one frame read, expected words snapshot from the fifo stages
    task automatic frame();
        @(posedge clk);
        frame_rd <= 1'b1;
        for (int i = 0; i < NCH; i++) begin
            exq.push_back(cbr_word_t'{chan: CBR_CH_W'(i), last: i == NCH - 1, data: fifo[i]});
        end
        @(posedge clk);
        frame_rd <= 1'b0;
        for (int k = 0; k < 300 && (exq.size() > 0 || busy !== 1'b0); k++) begin
            @(posedge clk);
        end
        // a frame that never drains counts as a mismatch and ends the run
        if (exq.size() != 0 || busy !== 1'b0) begin
            failures++;
            finish_test();
        end
        repeat (3) @(posedge clk);
    endtask
    // flags and, in level format, the pin against the model
    task automatic chk_state();
        chk_sig(8'(flags), 8'(unread));
        chk_sig(8'(busy), 8'h00);
        if (!fmt) begin
            chk_sig(8'(pin_n), 8'(!unread[0]));
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // timeout, pin falls, restarts and stream checking
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            finish_test();
        end
        pin_q <= pin_n;
        if (pin_q === 1'b1 && pin_n === 1'b0) falls++;
        if (restart_conv === 1'b1) restarts++;
        if (!rst && word_valid === 1'b1 && word_ready === 1'b1) begin
            e = exq.pop_front();
            chk_word(word_data, e);
            fifo[e.chan] = pend[e.chan] ? obuf[e.chan] : fifo[e.chan];
            unread[e.chan] = pend[e.chan];
            pend[e.chan] = 1'b0;
        end
    end

    initial begin
        seed = 83949;
        {rst, conv_done, fmt, frame_rd, slow, sync_n} = 6'b100001;
        conv_data = '{default: '0};
        {unread, pend, cyc, falls, restarts, failures, num_checks} = '0;
        fifo = '{default: '0};
        obuf = '{default: '0};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        conv();
        chk_state();
        frame();
        chk_state();
        frame();
        conv();
        conv();
        chk_state();
        slow <= 1'b1;
        frame();
        chk_state();
        frame();
        chk_state();
        repeat (3) conv();
        frame();
        chk_state();
        fmt <= 1'b1; // the format input and slow are the only settings ever touched
        falls = 0;
        repeat (4) conv();
        chk_sig(8'(falls), 8'h02);
        frame();
        frame();
        chk_state();
        fmt <= 1'b0;
        slow <= 1'b0;
        conv();
        sync_n <= 1'b0;
        repeat (4) @(posedge clk);
        sync_n <= 1'b1;
        repeat (4) @(posedge clk);
        {unread, pend} = '0;
        fifo = '{default: '0};
        obuf = '{default: '0};
        chk_sig(8'(restarts), 8'h01);
        chk_state();
        frame();
        finish_test();
    end
endmodule
